/* hw/icf_pkg.sv */
// Package with constants for the input capture block
package icf_pkg;
  localparam int ICF_FIFO_DEPTH = 4;
  localparam int ICF_PTR_W = 2;
  localparam int ICF_CNT_W = 3;
  localparam int ICF_PRE_W = 4;
  localparam logic [2:0] ICF_MODE_OFF = 3'h0;
  localparam logic [2:0] ICF_MODE_EDGE = 3'h1;
  localparam logic [2:0] ICF_MODE_FALL = 3'h2;
  localparam logic [2:0] ICF_MODE_RISE = 3'h3;
  localparam logic [2:0] ICF_MODE_PRE4 = 3'h4;
  localparam logic [2:0] ICF_MODE_PRE16 = 3'h5;
  localparam logic [2:0] ICF_MODE_BOTH = 3'h6;
  localparam logic [2:0] ICF_MODE_WAKE = 3'h7;
  localparam logic [3:0] ICF_PRE4_LAST = 4'h3;
  localparam logic [3:0] ICF_PRE16_LAST = 4'hF;
  localparam int ICF_ENABLE_BIT = 15;
  localparam int ICF_TMR_SEL_BIT = 7;
  localparam int ICF_IRQ_CNT_HI = 6;
  localparam int ICF_IRQ_CNT_LO = 5;
  localparam int ICF_OVF_BIT = 4;
  localparam int ICF_BNE_BIT = 3;
  localparam logic [31:0] ICF_WORD_RESET = 32'h0000_0000;
  localparam logic [2:0] ICF_CNT_RESET = 3'h0;
  localparam logic [3:0] ICF_PRE_RESET = 4'h0;
endpackage

/* hw/icf_pin_prescaler.sv */
// Pin-clocked prescaler counting capture input rising edges
`timescale 1ns/1ps
module icf_pin_prescaler
  import icf_pkg::*;
(
  input wire logic capture_input_pin,
  input wire logic clr_n,
  input wire logic four_mode,
  output logic event_toggle,
  output logic rise_toggle
);
  logic [ICF_PRE_W-1:0] count;
  logic [ICF_PRE_W-1:0] last;

  assign last = four_mode ? ICF_PRE4_LAST : ICF_PRE16_LAST;

  // Clocked by the pin so narrow pulses count
  always_ff @(posedge capture_input_pin or negedge clr_n) begin
    if (!clr_n) begin
      count <= ICF_PRE_RESET;
      event_toggle <= 1'b0;
      rise_toggle <= 1'b0;
    end else begin
      rise_toggle <= ~rise_toggle;
      if (count >= last) begin
        count <= ICF_PRE_RESET;
        event_toggle <= ~event_toggle;
      end else begin
        count <= count + 4'h1;
      end
    end
  end
endmodule // icf_pin_prescaler

/* hw/icf_capture.sv */
// Input capture unit with four-entry capture FIFO
//
// Contract
// - Modes 100/101 capture every 4th/16th rise
// - Prescale counter pulse synchronized before capture
// - Stored value is time base 2-3 cycles later
// - Interrupt after 1-4 captures per count field
// - Mode switch keeps prescale counter value
// - Disable or reset clears prescale counter
// - Pin-clocked flop registers prescaled/wake edges
// - Mode 001 captures both edges
// - Edge mode: no prescaler, overrun untouched
// - Edge mode interrupts on every capture
// - Mode 111 wakes on rise during sleep
// - Wake mode stores nothing, ignores selects
// - Wake interrupt drops on leaving sleep
// - Four-deep FIFO, software writes ignored
// - Not-empty and overrun status flags
// - Disable or reset clears flags, empties FIFO
// - Not-empty holds until all entries read
// - Read advances pointer; upper half last
// - Full capture blocks; sets overrun and error irq except in edge mode
// - Overrun clears on disable, empty, reset
// - Disabled mode ignores edges, FIFO readable
// - Not-empty low clears interrupt count
// - Timer select and 32-bit halves mapping
`timescale 1ns/1ps
module icf_capture
  import icf_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic capture_input_pin,
  input wire logic [15:0] capture_control_word,
  input wire logic capture_32bit,
  input wire logic device_asleep,
  input wire logic [15:0] timer_a_count,
  input wire logic [15:0] timer_b_count,
  input wire logic fifo_read_low,
  input wire logic fifo_read_high,
  input wire logic capture_fifo_write,
  input wire logic [31:0] capture_fifo_write_data,
  output logic [31:0] capture_fifo_port,
  output logic fifo_not_empty_flag,
  output logic fifo_overrun_flag,
  output logic capture_irq,
  output logic capture_error_irq,
  output logic wake_irq
);
  typedef struct packed {
    logic [ICF_FIFO_DEPTH-1:0][31:0] mem;
    logic [ICF_PTR_W-1:0] rd_ptr;
    logic [ICF_PTR_W-1:0] wr_ptr;
    logic [ICF_CNT_W-1:0] fill;
    logic [ICF_CNT_W-1:0] irq_count;
    logic overrun;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic ev_s1;
    logic ev_s2;
    logic ev_s3;
    logic rise_s1;
    logic rise_s2;
    logic rise_s3;
    logic [31:0] rd_data;
    logic bne_out;
    logic ovf_out;
    logic irq_out;
    logic err_out;
    logic wake_out;
  } icf_state_t;

  icf_state_t st;
  icf_state_t next_st;

  logic [2:0] mode;
  logic enable;
  logic [1:0] irq_sel;
  logic tmr_sel;
  logic pre_clr_n;
  logic event_toggle;
  logic rise_toggle;
  logic capture_event;
  logic fifo_full;
  logic read_pop;
  logic [31:0] time_value;
  logic [ICF_CNT_W-1:0] irq_target;

  assign mode = capture_control_word[2:0];
  assign enable = capture_control_word[ICF_ENABLE_BIT];
  assign irq_sel = capture_control_word[ICF_IRQ_CNT_HI:ICF_IRQ_CNT_LO];
  assign tmr_sel = capture_control_word[ICF_TMR_SEL_BIT];
  // Counter kept across mode changes; only disable or reset clear it
  assign pre_clr_n = rst_n & enable;

  function automatic logic [ICF_PTR_W-1:0] ptr_inc(input logic [ICF_PTR_W-1:0] p);
    ptr_inc = p + 2'h1;
  endfunction

  // Change between two synchronizer stages
  function automatic logic toggled(input logic newer, input logic older);
    toggled = newer ^ older;
  endfunction

  // Edge-detect mode decode
  function automatic logic is_edge_mode(input logic [2:0] m);
    is_edge_mode = (m == ICF_MODE_EDGE);
  endfunction

  icf_pin_prescaler u_pre (
    .capture_input_pin(capture_input_pin),
    .clr_n(pre_clr_n),
    .four_mode(mode == ICF_MODE_PRE4),
    .event_toggle(event_toggle),
    .rise_toggle(rise_toggle)
  );

  always_comb begin
    next_st = st;
    capture_event = 1'b0;
    read_pop = 1'b0;
    time_value = ICF_WORD_RESET;
    irq_target = {1'b0, irq_sel} + 3'h1;
    fifo_full = (st.fill == 3'(ICF_FIFO_DEPTH));
    // Synchronizers: first stage read only by second stage
    next_st.pin_s1 = capture_input_pin;
    next_st.pin_s2 = st.pin_s1;
    next_st.pin_s3 = st.pin_s2;
    next_st.ev_s1 = event_toggle;
    next_st.ev_s2 = st.ev_s1;
    next_st.ev_s3 = st.ev_s2;
    next_st.rise_s1 = rise_toggle;
    next_st.rise_s2 = st.rise_s1;
    next_st.rise_s3 = st.rise_s2;
    // 32-bit: B low, A high; 16-bit: select 0 is A, 1 is B
    if (capture_32bit) begin
      time_value = {timer_a_count, timer_b_count};
    end else begin
      time_value = {16'h0000, tmr_sel ? timer_b_count : timer_a_count};
    end
    case (mode)
      ICF_MODE_OFF: capture_event = 1'b0;
      ICF_MODE_EDGE: capture_event = toggled(st.pin_s2, st.pin_s3);
      ICF_MODE_FALL: capture_event = st.pin_s3 & ~st.pin_s2;
      ICF_MODE_RISE: capture_event = st.pin_s2 & ~st.pin_s3;
      ICF_MODE_PRE4, ICF_MODE_PRE16: capture_event = toggled(st.ev_s2, st.ev_s3);
      ICF_MODE_BOTH: capture_event = toggled(st.pin_s2, st.pin_s3);
      ICF_MODE_WAKE: capture_event = 1'b0;
      default: capture_event = 1'b0;
    endcase
    if (!enable) begin
      capture_event = 1'b0;
    end
    // Pop on full read or upper half in 32-bit; never when empty
    read_pop = (capture_32bit ? fifo_read_high : (fifo_read_low | fifo_read_high)) && (st.fill != 3'h0);
    // Software write port has no effect on contents
    next_st.err_out = 1'b0;
    next_st.irq_out = 1'b0;
    if (read_pop) begin
      next_st.rd_ptr = ptr_inc(st.rd_ptr);
      next_st.fill = st.fill - 3'h1;
    end
    if (capture_event) begin
      if (fifo_full || st.overrun) begin
        if (!is_edge_mode(mode)) begin
          next_st.overrun = 1'b1;
          next_st.err_out = 1'b1;
        end
        if (is_edge_mode(mode) || irq_sel == 2'h0) begin
          next_st.irq_out = 1'b1;
        end
      end else begin
        next_st.mem[st.wr_ptr] = time_value;
        next_st.wr_ptr = ptr_inc(st.wr_ptr);
        next_st.fill = next_st.fill + 3'h1;
        if (is_edge_mode(mode) || st.irq_count + 3'h1 >= irq_target) begin
          next_st.irq_out = 1'b1;
          next_st.irq_count = ICF_CNT_RESET;
        end else begin
          next_st.irq_count = st.irq_count + 3'h1;
        end
      end
    end
    if (next_st.fill == 3'h0) begin
      next_st.irq_count = ICF_CNT_RESET;
      if (read_pop) begin
        next_st.overrun = 1'b0;
      end
    end
    // Wake on pin rise while asleep; drop on wake
    if (enable && mode == ICF_MODE_WAKE && device_asleep) begin
      if (toggled(st.rise_s2, st.rise_s3)) begin
        next_st.wake_out = 1'b1;
      end
    end else begin
      next_st.wake_out = 1'b0;
    end
    next_st.rd_data = next_st.mem[next_st.rd_ptr];
    next_st.bne_out = (next_st.fill != 3'h0);
    next_st.ovf_out = next_st.overrun;
    if (!enable) begin
      next_st.rd_ptr = '0;
      next_st.wr_ptr = '0;
      next_st.fill = ICF_CNT_RESET;
      next_st.irq_count = ICF_CNT_RESET;
      next_st.overrun = 1'b0;
      next_st.bne_out = 1'b0;
      next_st.ovf_out = 1'b0;
      next_st.irq_out = 1'b0;
      next_st.err_out = 1'b0;
      // Flush toggle chains with the cleared prescaler, no stale event on enable
      next_st.ev_s1 = 1'b0;
      next_st.ev_s2 = 1'b0;
      next_st.ev_s3 = 1'b0;
      next_st.rise_s1 = 1'b0;
      next_st.rise_s2 = 1'b0;
      next_st.rise_s3 = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign capture_fifo_port = st.rd_data;
  assign fifo_not_empty_flag = st.bne_out;
  assign fifo_overrun_flag = st.ovf_out;
  assign capture_irq = st.irq_out;
  assign capture_error_irq = st.err_out;
  assign wake_irq = st.wake_out;
endmodule // icf_capture

/* verification/icf_monitor.sv */
// Assertion checker for the input capture block
`timescale 1ns/1ps
module icf_monitor
  import icf_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic capture_input_pin,
  input wire logic [15:0] capture_control_word,
  input wire logic device_asleep,
  input wire logic fifo_not_empty_flag,
  input wire logic fifo_overrun_flag,
  input wire logic capture_error_irq,
  input wire logic wake_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic [2:0] mode = capture_control_word[2:0];
  wire logic on = capture_control_word[15];
  a_disable_clears: assert property (!on |=> !fifo_not_empty_flag && !fifo_overrun_flag)
    else $error("flags set while disabled");
  a_edge_no_ovf: assert property (mode == ICF_MODE_EDGE && !fifo_overrun_flag |=> !fifo_overrun_flag)
    else $error("overrun in edge mode");
  a_edge_sync: assert property (on && mode == ICF_MODE_EDGE && !fifo_not_empty_flag && $rose(capture_input_pin)
    |-> ##[2:4] fifo_not_empty_flag) else $error("edge capture late");
  a_wake_drop: assert property (!device_asleep |=> !wake_irq) else $error("wake held while awake");
  a_wake_cause: assert property ($rose(wake_irq) |-> mode == ICF_MODE_WAKE && $past(device_asleep))
    else $error("wake without cause");
  a_wake_no_store: assert property (on && mode == ICF_MODE_WAKE && $past(mode, 4) == ICF_MODE_WAKE
    && !fifo_not_empty_flag |=> !fifo_not_empty_flag) else $error("wake mode stored");
  a_ovf_needs_data: assert property (fifo_overrun_flag |-> fifo_not_empty_flag) else $error("overrun when empty");
  a_err_when_full: assert property (capture_error_irq |-> fifo_not_empty_flag) else $error("error irq when empty");
  c_overrun: cover property ($rose(fifo_overrun_flag));
  c_wake: cover property ($rose(wake_irq));
  c_error: cover property (capture_error_irq);
endmodule // icf_monitor

bind icf_capture icf_monitor u_icf_monitor (.core_clk(core_clk), .rst_n(rst_n),
  .capture_input_pin(capture_input_pin), .capture_control_word(capture_control_word),
  .device_asleep(device_asleep), .fifo_not_empty_flag(fifo_not_empty_flag),
  .fifo_overrun_flag(fifo_overrun_flag), .capture_error_irq(capture_error_irq), .wake_irq(wake_irq));

/* verification/icf_pin_model.sv */
// Driver standing in for the external capture signal
`timescale 1ns/1ps
module icf_pin_model (
  input wire logic core_clk,
  input wire logic pulse_req,
  input wire logic narrow,
  output logic capture_input_pin
);
  initial capture_input_pin = 1'b0;
  always @(posedge core_clk) begin
    if (pulse_req && narrow) begin
      #1 capture_input_pin = 1'b1; // Pulse shorter than a clock period
      #1 capture_input_pin = 1'b0;
    end else if (pulse_req) begin
      capture_input_pin <= 1'b1;
      repeat (3) @(posedge core_clk);
      capture_input_pin <= 1'b0;
    end
  end
endmodule // icf_pin_model

/* verification/test_icf_capture.sv */
// Self-checking testbench for the input capture block
`timescale 1ns/1ps
module test_icf_capture;
  import icf_pkg::*;
  logic core_clk = 0, rst_n = 0, pin_req = 0, narrow = 0, capture_32bit = 0, device_asleep = 0, capture_input_pin;
  logic fifo_read_low = 0, fifo_read_high = 0, capture_fifo_write = 0;
  logic [15:0] capture_control_word = 16'h0000, timer_a_count = 16'h0000, timer_b_count = 16'h0000, t0;
  logic [31:0] capture_fifo_write_data = 32'h0000_0000, capture_fifo_port;
  logic fifo_not_empty_flag, fifo_overrun_flag, capture_irq, capture_error_irq, wake_irq;
  int error_cnt = 0, checks = 0, irqs = 0, errs = 0, i0, e0, seed = 17209;
  logic [2:0] simple_modes [4] = '{ICF_MODE_OFF, ICF_MODE_RISE, ICF_MODE_FALL, ICF_MODE_BOTH};
  icf_capture dut (
    .core_clk(core_clk), .rst_n(rst_n), .capture_input_pin(capture_input_pin),
    .capture_control_word(capture_control_word), .capture_32bit(capture_32bit), .device_asleep(device_asleep),
    .timer_a_count(timer_a_count), .timer_b_count(timer_b_count), .fifo_read_low(fifo_read_low),
    .fifo_read_high(fifo_read_high), .capture_fifo_write(capture_fifo_write),
    .capture_fifo_write_data(capture_fifo_write_data), .capture_fifo_port(capture_fifo_port),
    .fifo_not_empty_flag(fifo_not_empty_flag), .fifo_overrun_flag(fifo_overrun_flag), .capture_irq(capture_irq),
    .capture_error_irq(capture_error_irq), .wake_irq(wake_irq)
  );
  icf_pin_model pin (.core_clk(core_clk), .pulse_req(pin_req), .narrow(narrow), .capture_input_pin(capture_input_pin));
  initial forever #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    timer_a_count <= timer_a_count + 16'h0001;
    irqs <= irqs + int'(capture_irq === 1'b1);
    errs <= errs + int'(capture_error_irq === 1'b1);
  end
  // Interrupts expected from wide pulses in a pin-sampled mode
  function automatic int exp_irqs(input logic [2:0] mode, input int n);
    case (mode)
      ICF_MODE_EDGE, ICF_MODE_BOTH: exp_irqs = 2 * n;
      ICF_MODE_RISE, ICF_MODE_FALL: exp_irqs = n;
      default: exp_irqs = 0;
    endcase
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic pulses(input int n, input logic nr);
    repeat (n) begin
      @(posedge core_clk);
      pin_req <= 1'b1;
      narrow <= nr;
      @(posedge core_clk);
      pin_req <= 1'b0;
      cyc(9 + ($unsigned($random(seed)) % 3));
    end
  endtask
  task automatic setup(input logic [2:0] mode, input logic [1:0] sel);
    @(posedge core_clk);
    capture_control_word <= 16'h0000;
    cyc(2);
    capture_control_word <= {1'b1, 7'h00, 1'b0, sel, 2'b00, mode};
  endtask
  task automatic rd(input logic hi);
    @(posedge core_clk);
    fifo_read_high <= hi;
    fifo_read_low <= ~hi;
    @(posedge core_clk);
    fifo_read_high <= 1'b0;
    fifo_read_low <= 1'b0;
    @(posedge core_clk);
  endtask
  initial begin
    cyc(12);
    check({fifo_not_empty_flag, fifo_overrun_flag}, 32'h0, "flags in reset");
    rst_n <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      setup(ICF_MODE_PRE4, s[1:0]);
      i0 = irqs;
      pulses(4 * s + 3, 1'b1);
      check(irqs - i0, 32'h0, "early irq");
      pulses(1, 1'b1);
      check(irqs - i0, 32'h1, "irq count");
      check(fifo_not_empty_flag, 32'h1, "not empty");
    end
    e0 = errs;
    pulses(4, 1'b1);
    check(fifo_overrun_flag, 32'h1, "overrun");
    check(errs - e0, 32'h1, "error irq");
    // Reads stop at the stored count, never from empty
    repeat (4) rd(1'b1);
    check({fifo_not_empty_flag, fifo_overrun_flag}, 32'h0, "drained");
    setup(ICF_MODE_PRE16, 2'b00);
    pulses(15, 1'b1);
    check(fifo_not_empty_flag, 32'h0, "pre16 early");
    pulses(1, 1'b1);
    check(fifo_not_empty_flag, 32'h1, "pre16 capture");
    i0 = irqs;
    pulses(2, 1'b1);
    capture_control_word[2:0] <= ICF_MODE_PRE4;
    pulses(2, 1'b1);
    check(irqs - i0, 32'h1, "mode switch count");
    capture_32bit <= 1'b1;
    timer_b_count <= 16'($random(seed));
    setup(ICF_MODE_EDGE, 2'b11);
    i0 = irqs;
    t0 = timer_a_count;
    pulses(3, 1'b0);
    check(irqs - i0, exp_irqs(ICF_MODE_EDGE, 3), "edge irqs");
    check(fifo_overrun_flag, 32'h0, "edge overrun");
    check(capture_fifo_port[15:0], timer_b_count, "low half");
    check((capture_fifo_port[31:16] - t0) inside {[16'h0003:16'h0008]}, 32'h1, "capture time");
    rd(1'b0);
    check(fifo_not_empty_flag, 32'h1, "low read");
    repeat (4) rd(1'b1);
    check(fifo_not_empty_flag, 32'h0, "edge drained");
    foreach (simple_modes[k]) begin
      setup(simple_modes[k], 2'b00);
      i0 = irqs;
      pulses(1, 1'b0);
      check(irqs - i0, exp_irqs(simple_modes[k], 1), "simple irqs");
      check(fifo_not_empty_flag, 32'(simple_modes[k] != ICF_MODE_OFF), "simple store");
    end
    capture_32bit <= 1'b0;
    device_asleep <= 1'b1;
    setup(ICF_MODE_WAKE, 2'b00);
    capture_fifo_write <= 1'b1;
    capture_fifo_write_data <= $random(seed);
    pulses(1, 1'b1);
    check({wake_irq, fifo_not_empty_flag}, 32'h2, "wake");
    device_asleep <= 1'b0;
    cyc(2);
    check(wake_irq, 32'h0, "wake drop");
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    finish_test;
  end
endmodule // test_icf_capture
